// file: scc_pkg.sv
// register map, field positions and reset values of the system config block
package scc_pkg;
	localparam int                SCC_AW          = 16;
	// printed offsets are word indexes; byte address is four times the index
	localparam logic [SCC_AW-1:0] SCC_IDX_PCG1    = 16'h1c02;
	localparam logic [SCC_AW-1:0] SCC_IDX_PCG2    = 16'h1c03;
	localparam logic [SCC_AW-1:0] SCC_IDX_SLEW    = 16'h1c16;
	localparam logic [SCC_AW-1:0] SCC_IDX_PULL1   = 16'h1c17;
	localparam logic [SCC_AW-1:0] SCC_IDX_PULL2   = 16'h1c18;
	localparam logic [SCC_AW-1:0] SCC_IDX_PULL3   = 16'h1c19;
	localparam logic [SCC_AW-1:0] SCC_IDX_USBSYS  = 16'h1c32;
	localparam logic [SCC_AW-1:0] SCC_IDX_REG     = 16'h7004;
	localparam logic [SCC_AW-1:0] SCC_IDX_IDLE    = 16'h1c40;
	localparam logic [SCC_AW-1:0] SCC_IDX_PSRC    = 16'h1c04;
	localparam logic [SCC_AW-1:0] SCC_IDX_PRC     = 16'h1c05;
	localparam logic [SCC_AW-1:0] SCC_IDX_BOOT    = 16'h1c41;
	localparam logic [SCC_AW-1:0] SCC_IDX_STAT    = 16'h1c42;
	localparam logic [SCC_AW-1:0] SCC_IDX_RTC_LO  = 16'h1900;
	localparam logic [SCC_AW-1:0] SCC_IDX_RTC_HI  = 16'h197f;
	// regulator control fields
	localparam int                SCC_USB_REG_ON  = 0;
	localparam int                SCC_CORE_VSEL   = 1;
	localparam logic [15:0]       SCC_REG_MASK    = 16'h0003;
	localparam logic [15:0]       SCC_REG_RST     = 16'h0000;
	// usb system control fields
	localparam int                SCC_BYTE_LO     = 0;
	localparam int                SCC_OSC_DIS     = 4;
	localparam int                SCC_OSC_BIAS    = 5;
	localparam logic [15:0]       SCC_USBSYS_MASK = 16'h0033;
	localparam logic [15:0]       SCC_USBSYS_RST  = 16'h0030;
	localparam logic [1:0]        SCC_BYTE_WORD   = 2'h0;
	localparam logic [1:0]        SCC_BYTE_HIGH   = 2'h1;
	localparam logic [1:0]        SCC_BYTE_LOW    = 2'h2;
	localparam logic [15:0]       SCC_PCG_RST     = 16'hffff;
	localparam logic [15:0]       SCC_SLEW_MASK   = 16'h0001;
	localparam logic [15:0]       SCC_SLEW_RST    = 16'h0000;
	localparam logic [15:0]       SCC_PULL_RST    = 16'h0000;
	localparam logic [15:0]       SCC_IDLE_MASK   = 16'h00ff;
	localparam int                SCC_IDLE_CPU    = 0;
	localparam logic [15:0]       SCC_IDLE_RST    = 16'h0000;
	localparam logic [15:0]       SCC_IDLE_BOOT   = 16'h00fe;
	// boot clock request codes
	localparam logic [1:0]        SCC_CLK_RTC     = 2'h0;
	localparam logic [1:0]        SCC_CLK_BYPASS  = 2'h1;
	localparam logic [1:0]        SCC_CLK_PLL60   = 2'h2;
	localparam logic [1:0]        SCC_CLK_USB36   = 2'h3;
	localparam int                SCC_RTC_MULT    = 375;
	localparam int                SCC_PLL_MHZ     = 60;
	localparam int                SCC_SPI_MHZ     = 15;
	localparam int                SCC_SPI_DIV     = SCC_PLL_MHZ / SCC_SPI_MHZ;
	localparam int                SCC_USB_MHZ     = 36;
	localparam logic [1:0]        SCC_HTRANS_NSEQ = 2'h2;
	localparam logic [2:0]        SCC_HSIZE_WORD  = 3'h2;
endpackage

// file: scc_top.sv
// system configuration and clock control registers on an ahb-lite slave
//
// The implementer's own choice: register access over AHB-Lite.
module scc_top
	import scc_pkg::*;
#(
	parameter int NUM_PERIPH = 8
) (
	// ahb-lite slave
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// board pins and status
	input  wire logic              clock_select_pin,
	input  wire logic              core_regulator_enable_pin,
	input  wire logic              core_power_down,
	input  wire logic              rtc_osc_running,
	// boot sequencer handshake
	input  wire logic              boot_query_start,
	input  wire logic              boot_query_fail,
	input  wire logic              boot_usb_attempt,
	input  wire logic              boot_done,
	// rtc register space access
	output logic                   rtc_access_en,
	// regulator controls
	output logic                   core_regulator_on,
	output logic                   core_voltage_select,
	output logic                   usb_regulator_on,
	// usb controls
	output logic      [1:0]        usb_byte_access_select,
	output logic                   usb_osc_disable,
	output logic                   usb_osc_bias_disable,
	// clocks, idles, resets
	output logic      [31:0]       periph_clock_gate,
	output logic      [15:0]       idle_domain,
	output logic      [15:0]       periph_reset,
	output logic      [1:0]        clock_gen_mode,
	output logic      [8:0]        clock_gen_mult,
	// pads
	output logic      [47:0]       pull_enable,
	output logic                   bus_holder_en,
	output logic                   clock_output_slow
);
	import scc_pkg::*;

	typedef enum logic [1:0] {
		SCC_IDLE,
		SCC_DATA
	} scc_phase_t;

	scc_phase_t  phase_q;
	logic        wr_q;
	logic [15:0] idx_q;
	logic        rtc_q;
	logic [15:0] pcg1_q, pcg2_q, slew_q, reg_q, usbsys_q, idle_q;
	logic [15:0] psrc_q, prc_q, boot_q;
	logic [15:0] pull_q [3];
	logic [15:0] rdata_d;
	logic [3:0]  query_q;
	logic        csel_q;
	logic        csel_taken_q;
	logic        take;
	logic        wr_en;
	logic [15:0] wdata;

	function automatic logic in_rtc(input logic [15:0] idx);
		in_rtc = (idx >= SCC_IDX_RTC_LO) && (idx <= SCC_IDX_RTC_HI);
	endfunction

	assign take  = hsel && hready && (htrans == SCC_HTRANS_NSEQ);
	assign wr_en = (phase_q == SCC_DATA) && wr_q;
	assign wdata = hwdata[15:0];

	// address phase capture; writes take no wait state, reads take one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= SCC_IDLE;
			wr_q    <= 1'b0;
			idx_q   <= 16'h0000;
			rtc_q   <= 1'b0;
		end else begin
			phase_q <= take ? SCC_DATA : SCC_IDLE;
			wr_q    <= take && hwrite && (hsize == SCC_HSIZE_WORD);
			idx_q   <= haddr[17:2];
			rtc_q   <= in_rtc(haddr[17:2]);
		end
	end

	// regulator control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reg_q <= SCC_REG_RST;
		end else if (wr_en && idx_q == SCC_IDX_REG) begin
			reg_q <= wdata & SCC_REG_MASK;
		end
	end

	// usb system control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			usbsys_q <= SCC_USBSYS_RST;
		end else if (wr_en && idx_q == SCC_IDX_USBSYS) begin
			usbsys_q <= wdata & SCC_USBSYS_MASK;
		end
	end

	// peripheral clock gates: boot query and software writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pcg1_q  <= SCC_PCG_RST;
			pcg2_q  <= SCC_PCG_RST;
			query_q <= 4'h0;
		end else if (boot_done) begin
			pcg1_q <= SCC_PCG_RST;
			pcg2_q <= SCC_PCG_RST;
		end else if (boot_query_start) begin
			pcg1_q[query_q] <= 1'b0;
		end else if (boot_query_fail) begin
			pcg1_q[query_q] <= 1'b1;
			query_q         <= query_q + 4'h1;
		end else if (wr_en && idx_q == SCC_IDX_PCG1) begin
			pcg1_q <= wdata;
		end else if (wr_en && idx_q == SCC_IDX_PCG2) begin
			pcg2_q <= wdata;
		end
	end

	// idle domains
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_q <= SCC_IDLE_RST;
		end else if (boot_done) begin
			idle_q <= SCC_IDLE_BOOT;
		end else if (wr_en && idx_q == SCC_IDX_IDLE) begin
			idle_q <= wdata & SCC_IDLE_MASK;
		end
	end

	// peripheral reset counter and control; counter holds reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			psrc_q <= 16'h0000;
			prc_q  <= 16'h0000;
		end else if (wr_en && idx_q == SCC_IDX_PSRC) begin
			psrc_q <= wdata;
		end else if (wr_en && idx_q == SCC_IDX_PRC) begin
			prc_q <= wdata;
		end else if (psrc_q != 16'h0000) begin
			psrc_q <= psrc_q - 16'h0001;
		end
	end

	// slew and pull inhibits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slew_q <= SCC_SLEW_RST;
		end else if (wr_en && idx_q == SCC_IDX_SLEW) begin
			slew_q <= wdata & SCC_SLEW_MASK;
		end
	end

	generate
		for (genvar g = 0; g < 3; g++) begin : g_pull
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pull_q[g] <= SCC_PULL_RST;
				end else if (wr_en && idx_q == SCC_IDX_PULL1 + 16'(g)) begin
					pull_q[g] <= wdata;
				end
			end
		end
	endgenerate

	// clock select caught once after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			csel_q       <= 1'b0;
			csel_taken_q <= 1'b0;
		end else if (!csel_taken_q) begin
			csel_q       <= clock_select_pin;
			csel_taken_q <= 1'b1;
		end
	end

	// boot clock generator setting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_gen_mode <= SCC_CLK_RTC;
			clock_gen_mult <= 9'h000;
			boot_q         <= 16'h0000;
		end else if (!csel_taken_q) begin
			clock_gen_mode <= clock_select_pin ? SCC_CLK_BYPASS : SCC_CLK_RTC;
			clock_gen_mult <= clock_select_pin ? 9'h000 : 9'(SCC_RTC_MULT);
		end else if (boot_usb_attempt) begin
			clock_gen_mode <= SCC_CLK_USB36;
			boot_q         <= 16'(SCC_USB_MHZ);
		end else if (csel_q && clock_gen_mode == SCC_CLK_BYPASS) begin
			clock_gen_mode <= SCC_CLK_PLL60;
			boot_q         <= {8'(SCC_SPI_DIV), 8'(SCC_PLL_MHZ)};
		end
	end

	// read mux; rtc range always reads zero, oscillator or not
	always_comb begin
		rdata_d = 16'h0000;
		if (idx_q == SCC_IDX_REG) begin
			rdata_d = reg_q;
		end else if (idx_q == SCC_IDX_USBSYS) begin
			rdata_d = usbsys_q;
		end else if (idx_q == SCC_IDX_PCG1) begin
			rdata_d = pcg1_q;
		end else if (idx_q == SCC_IDX_PCG2) begin
			rdata_d = pcg2_q;
		end else if (idx_q == SCC_IDX_IDLE) begin
			rdata_d = idle_q;
		end else if (idx_q == SCC_IDX_PSRC) begin
			rdata_d = psrc_q;
		end else if (idx_q == SCC_IDX_PRC) begin
			rdata_d = prc_q;
		end else if (idx_q == SCC_IDX_SLEW) begin
			rdata_d = slew_q;
		end else if (idx_q >= SCC_IDX_PULL1 && idx_q <= SCC_IDX_PULL3) begin
			rdata_d = pull_q[2'(idx_q - SCC_IDX_PULL1)];
		end else if (idx_q == SCC_IDX_BOOT) begin
			rdata_d = boot_q;
		end else if (idx_q == SCC_IDX_STAT) begin
			rdata_d = {13'h0000, rtc_osc_running, clock_gen_mode == SCC_CLK_USB36,
				csel_q};
		end
	end

	// read data registered; a read takes one wait state so the bus
	// outputs come from flops and a write just before a read is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (take && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (!hreadyout) begin
				hrdata    <= {16'h0000, rdata_d};
				hreadyout <= 1'b1;
			end
		end
	end

	// pin outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rtc_access_en          <= 1'b0;
			core_regulator_on      <= 1'b0;
			core_voltage_select    <= 1'b0;
			usb_regulator_on       <= 1'b0;
			usb_byte_access_select <= SCC_BYTE_WORD;
			usb_osc_disable        <= 1'b1;
			usb_osc_bias_disable   <= 1'b1;
			periph_clock_gate      <= {SCC_PCG_RST, SCC_PCG_RST};
			idle_domain            <= SCC_IDLE_RST;
			periph_reset           <= 16'h0000;
			pull_enable            <= 48'h0;
			bus_holder_en          <= 1'b0;
			clock_output_slow      <= 1'b0;
		end else begin
			rtc_access_en          <= rtc_osc_running;
			core_regulator_on      <= core_regulator_enable_pin;
			core_voltage_select    <= reg_q[SCC_CORE_VSEL];
			usb_regulator_on       <= reg_q[SCC_USB_REG_ON];
			usb_byte_access_select <= usbsys_q[SCC_BYTE_LO+:2];
			usb_osc_disable        <= usbsys_q[SCC_OSC_DIS];
			usb_osc_bias_disable   <= usbsys_q[SCC_OSC_BIAS];
			periph_clock_gate      <= {pcg2_q, pcg1_q};
			idle_domain            <= idle_q;
			periph_reset           <= (psrc_q != 16'h0000) ? prc_q : 16'h0000;
			pull_enable            <= core_power_down ? 48'h0 :
				~{pull_q[2], pull_q[1], pull_q[0]};
			bus_holder_en          <= core_power_down;
			clock_output_slow      <= slew_q[0];
		end
	end

	// rtc range reads zero whether or not the oscillator runs
	rtc_blank_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q == SCC_DATA && rtc_q && !wr_q) |=> hrdata == 32'h0)
		else $error("rtc range not blank");
	reg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && idx_q == SCC_IDX_REG) |=> ##1 usb_regulator_on ==
		$past(hwdata[0], 2))
		else $error("usb regulator not following write");
	boot_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
		boot_done |=> ##1 (periph_clock_gate == 32'hffffffff &&
		!idle_domain[SCC_IDLE_CPU] && idle_domain[1]))
		else $error("boot end state wrong");
	pull_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
		core_power_down |=> (pull_enable == 48'h0 && bus_holder_en))
		else $error("pulls active in power down");
	csel_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		csel_taken_q |=> $stable(csel_q))
		else $error("clock select changed");
	rtc_mult_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!csel_taken_q && !clock_select_pin) |=> clock_gen_mult == 9'h177)
		else $error("rtc multiplier wrong");
	query_fail_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(boot_query_fail && !boot_done && !boot_query_start) |=>
		pcg1_q[$past(query_q)])
		else $error("query clock left on");
	usb_boot_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(boot_usb_attempt && csel_taken_q) |=> clock_gen_mode == SCC_CLK_USB36)
		else $error("usb boot clock not set");
endmodule

// file: tb_top.sv
// self-checking bench for the system configuration register block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scc_pkg::*;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, usb_byte_access_select, clock_gen_mode;
	logic [2:0]  hsize;
	wire logic   hready;
	logic        clock_select_pin, core_regulator_enable_pin;
	logic        core_power_down, rtc_osc_running;
	logic        boot_query_start, boot_query_fail, boot_usb_attempt;
	logic        boot_done, rtc_access_en, core_regulator_on;
	logic        core_voltage_select, usb_regulator_on, usb_osc_disable;
	logic        usb_osc_bias_disable, bus_holder_en, clock_output_slow;
	logic [31:0] periph_clock_gate;
	logic [15:0] idle_domain, periph_reset;
	logic [8:0]  clock_gen_mult;
	logic [47:0] pull_enable;
	int          n_fail, check_count;
	logic [15:0] model[int];
	logic [15:0] regs[8] = '{SCC_IDX_PCG1, SCC_IDX_PCG2, SCC_IDX_SLEW,
		SCC_IDX_PULL1, SCC_IDX_PULL2, SCC_IDX_PULL3, SCC_IDX_USBSYS,
		SCC_IDX_REG};

	// single slave, so its ready closes the bus loop
	assign hready = hreadyout;

	scc_top #(.NUM_PERIPH(8)) scc_top_i (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .clock_select_pin,
		.core_regulator_enable_pin, .core_power_down, .rtc_osc_running,
		.boot_query_start, .boot_query_fail, .boot_usb_attempt, .boot_done,
		.rtc_access_en, .core_regulator_on, .core_voltage_select,
		.usb_regulator_on, .usb_byte_access_select, .usb_osc_disable,
		.usb_osc_bias_disable, .periph_clock_gate, .idle_domain,
		.periph_reset, .clock_gen_mode, .clock_gen_mult, .pull_enable,
		.bus_holder_en, .clock_output_slow);

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [15:0] idx, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value reg %h expected %h seen %h", idx, e, g);
		end
	endtask

	task automatic chk_pin(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	// address phase held until ready, then data phase until ready
	task automatic xfer(input logic w, input logic [15:0] idx,
		input logic [31:0] d, input logic [2:0] sz,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'b00};
		htrans <= SCC_HTRANS_NSEQ;
		hwrite <= w;
		hsize <= sz;
		do @(posedge hclk); while (hready !== 1'b1 && ++n < 64);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1 && ++n < 64);
		rd = hrdata;
		if (n >= 64) begin
			n_fail++;
			report_and_stop();
		end
	endtask

	task automatic init_model();
		foreach (regs[i]) model[regs[i]] = 16'h0;
		model[SCC_IDX_PCG1] = SCC_PCG_RST;
		model[SCC_IDX_PCG2] = SCC_PCG_RST;
		model[SCC_IDX_USBSYS] = SCC_USBSYS_RST;
	endtask

	function automatic logic [15:0] msk(input logic [15:0] idx);
		case (idx)
		SCC_IDX_REG: return SCC_REG_MASK;
		SCC_IDX_USBSYS: return SCC_USBSYS_MASK;
		SCC_IDX_SLEW: return SCC_SLEW_MASK;
		default: return 16'hffff;
		endcase
	endfunction

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] rd;
		xfer(1'b1, idx, d, SCC_HSIZE_WORD, rd);
		if (model.exists(idx)) model[idx] = d[15:0] & msk(idx);
	endtask

	task automatic rdchk(input logic [15:0] idx);
		logic [31:0] rd;
		xfer(1'b0, idx, $urandom, SCC_HSIZE_WORD, rd);
		chk_reg(idx, model.exists(idx) ? {16'h0, model[idx]} : 0, rd);
		chk_pin("hresp", 0, hresp);
	endtask

	task automatic chk_outs();
		foreach (regs[i]) rdchk(regs[i]);
		tick(1);
		chk_pin("gate", {model[SCC_IDX_PCG2], model[SCC_IDX_PCG1]}, periph_clock_gate);
		chk_pin("usb_reg", model[SCC_IDX_REG][0], usb_regulator_on);
		chk_pin("vsel", model[SCC_IDX_REG][1], core_voltage_select);
		chk_pin("bytesel", model[SCC_IDX_USBSYS][1:0], usb_byte_access_select);
		chk_pin("oscdis", model[SCC_IDX_USBSYS][4], usb_osc_disable);
		chk_pin("biasdis", model[SCC_IDX_USBSYS][5], usb_osc_bias_disable);
		chk_pin("slow", model[SCC_IDX_SLEW][0], clock_output_slow);
		chk_pin("pull_lo", ~{model[SCC_IDX_PULL2], model[SCC_IDX_PULL1]}, pull_enable[31:0]);
		chk_pin("pull_hi", {16'h0, ~model[SCC_IDX_PULL3]}, pull_enable[47:32]);
	endtask

	task automatic pulse(input int w);
		@(posedge hclk);
		boot_query_start <= (w == 0);
		boot_query_fail  <= (w == 1);
		boot_usb_attempt <= (w == 2);
		boot_done        <= (w == 3);
		@(posedge hclk);
		{boot_query_start, boot_query_fail, boot_usb_attempt, boot_done} <= 4'h0;
		tick(2);
	endtask

	initial begin
		#(25ns * 20000);
		n_fail++;
		report_and_stop();
	end

	initial begin
		logic [31:0] rd;
		{hsel, hwrite, hresetn} = 3'b000;
		{haddr, hwdata, htrans, hsize} = '0;
		{clock_select_pin, core_power_down, boot_query_start} = 3'b000;
		{boot_query_fail, boot_usb_attempt, boot_done} = 3'b000;
		{rtc_osc_running, core_regulator_enable_pin} = 2'b00;
		n_fail = 0;
		check_count = 0;
		void'($urandom(32'h9196));
		init_model();
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		tick(4);
		chk_pin("mode", SCC_CLK_RTC, clock_gen_mode);
		chk_pin("mult", SCC_RTC_MULT, clock_gen_mult);
		chk_outs();
		$display("test reset done");
		pulse(0);
		chk_pin("query_on", 32'hfffffffe, periph_clock_gate);
		pulse(1);
		chk_pin("query_off", 32'hffffffff, periph_clock_gate);
		pulse(2);
		chk_pin("usb_mode", SCC_CLK_USB36, clock_gen_mode);
		pulse(3);
		chk_pin("boot_gate", 32'hffffffff, periph_clock_gate);
		chk_pin("boot_idle", SCC_IDLE_BOOT, idle_domain);
		$display("test boot done");
		repeat (3) begin
			foreach (regs[i]) wr(regs[i], $urandom);
			chk_outs();
		end
		for (int b = 0; b < 3; b++) begin
			wr(SCC_IDX_USBSYS, b);
			chk_outs();
		end
		$display("test register access done");
		xfer(1'b1, SCC_IDX_SLEW, 32'h1 ^ model[SCC_IDX_SLEW], 3'h0, rd);
		rdchk(SCC_IDX_SLEW);
		rdchk(16'h1c50);
		rdchk(SCC_IDX_RTC_LO);
		rdchk(SCC_IDX_RTC_HI);
		$display("test refusals done");
		for (int k = 0; k < 2; k++) begin
			@(posedge hclk);
			rtc_osc_running <= k[0];
			core_regulator_enable_pin <= k[0];
			tick(3);
			chk_pin("rtc_en", k[0], rtc_access_en);
			chk_pin("core_on", k[0], core_regulator_on);
		end
		@(posedge hclk);
		core_power_down <= 1'b1;
		tick(3);
		chk_pin("pulls", 0, pull_enable);
		chk_pin("holder", 1, bus_holder_en);
		@(posedge hclk);
		core_power_down <= 1'b0;
		$display("test pins done");
		wr(SCC_IDX_PRC, 32'h00a5);
		wr(SCC_IDX_PSRC, 32'h64);
		tick(2);
		chk_pin("prst_on", 16'h00a5, periph_reset);
		tick(150);
		chk_pin("prst_off", 0, periph_reset);
		$display("test peripheral reset done");
		@(posedge hclk);
		hresetn <= 1'b0;
		clock_select_pin <= 1'b1;
		tick(2);
		@(posedge hclk);
		hresetn <= 1'b1;
		init_model();
		tick(1);
		chk_pin("mode_byp", SCC_CLK_BYPASS, clock_gen_mode);
		tick(1);
		chk_pin("mode_pll", SCC_CLK_PLL60, clock_gen_mode);
		model[SCC_IDX_BOOT] = {8'(SCC_PLL_MHZ / SCC_SPI_MHZ), 8'(SCC_PLL_MHZ)};
		model[SCC_IDX_STAT] = 16'h0005;
		rdchk(SCC_IDX_BOOT);
		rdchk(SCC_IDX_STAT);
		wr(SCC_IDX_REG, 32'h2);
		chk_outs();
		$display("test clock select done");
		report_and_stop();
	end
endmodule
